// >>> hdl/addr_step_calc.v
`timescale 1ns/10ps
`default_nettype none

module addr_step_calc (
    // descriptor fields
    input wire [31:0] start,
    input wire [15:0] count,
    input wire [1:0] beat_width,
    input wire [2:0] step_scale,
    input wire incr_en,
    input wire scale_en,
    // end address
    output wire [31:0] result
);
    wire [31:0] beats_plus;
    wire [31:0] span;
    wire [31:0] scaled;

    assign beats_plus = {29'h0, {1'b0, beat_width} + 3'h1};
    assign span = {16'h0, count} * beats_plus;
    assign scaled = scale_en ? (span << step_scale) : span;
    assign result = incr_en ? start + scaled : start;
endmodule // addr_step_calc

`default_nettype wire

// >>> hdl/desc_ram.v
`timescale 1ns/10ps
`default_nettype none

module desc_ram (
    // clock
    input wire clk,
    // port
    input wire [7:0] addr,
    input wire we,
    input wire [3:0] wstrb,
    input wire [31:0] wdata,
    output wire [31:0] rdata
);
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : lane
            reg [7:0] mem [0:255];
            reg [7:0] rd_q;
            // per-lane write gives byte and halfword access
            always @(posedge clk) begin
                if (we && wstrb[g]) begin
                    mem[addr] <= wdata[8*g+7:8*g];
                end
                rd_q <= mem[addr];
            end
            assign rdata[8*g+7:8*g] = rd_q;
        end
    endgenerate
endmodule // desc_ram

`default_nettype wire

// >>> hdl/dma_desc_ctrl.v
// How it works
// - with step target select 0 the source moves one beat per step and scaling goes to the destination.
// - with its enable bit set, the source end address is start plus count times (beat width + 1), scaled only when select is 1; else it is start.
// - destination incrementing is on only with its enable bit, and is one beat when select is 1.
// - the destination end address is start plus count times (beat width + 1), scaled when select is 0.
// - the count used is the beat count programmed in the descriptor before the transfer.
// - a controller reset asked while the controller or crc unit is on is ignored and errors.
// - the reset status bit reads 1 while a reset runs and 0 otherwise.
// - crc source 0x00 is idle, 0x01 the register interface, 0x20+n channel n up to 0x2d, rest reserved.
// - the crc source is locked until crc completes or the unit is disabled, shown by crc busy.
// - with a channel as source, crc completion comes from that channel.
// - enable-protected registers such as crc control take writes only while the unit is off.
// - 8, 16 and 32 bit accesses and byte or halfword parts of registers are supported.
// - a channel descriptor sits at base, or write-back base, plus channel times 0x10.
`timescale 1ns/10ps
`default_nettype none
`include "dma_desc_defs.vh"

module dma_desc_ctrl (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // completion events
    input wire [13:0] chan_block_done,
    input wire crc_io_done,
    // crc source and state
    output reg crc_io_select,
    output reg [13:0] crc_chan_select,
    output reg crc_complete,
    output reg crc_in_use,
    output reg dma_controller_enabled,
    output reg crc_enabled,
    // interrupt
    output reg irq
);
    // ----------------------------------------
    // engine states
    // ----------------------------------------
    localparam [5:0] S_IDLE = 6'b000001;
    localparam [5:0] S_CTRL = 6'b000010;
    localparam [5:0] S_CNT = 6'b000100;
    localparam [5:0] S_SRC = 6'b001000;
    localparam [5:0] S_DST = 6'b010000;
    localparam [5:0] S_CALC = 6'b100000;
    localparam integer RST_CYC = `RESET_CYCLES;
    localparam [3:0] RST_CNT_INIT = RST_CYC[3:0];

    reg [5:0] state_q;
    reg [3:0] calc_ch_q;
    reg [15:0] ctl_q;
    reg [15:0] cnt_q;
    reg [31:0] src_q;
    reg [31:0] src_res_q;
    reg [31:0] dst_res_q;
    reg [15:0] crc_ctrl_q;
    reg [31:0] base_q;
    reg [31:0] wrb_q;
    reg [3:0] rst_cnt_q;
    reg [2:0] int_q;
    reg [2:0] int_en_q;
    reg ram_apb_q;
    reg err_d;
    reg [31:0] rd_d;
    reg [3:0] ram_idx;

    wire [31:0] ram_q;
    wire [31:0] src_res;
    wire [31:0] dst_res;
    wire [31:0] desc_loc;
    wire [31:0] wrb_loc;
    wire [7:0] ram_addr;
    wire [5:0] crc_sel;
    wire [13:0] chan_hit;
    wire win;
    wire eng_owns;
    wire access;
    wire capture;
    wire commit;
    wire wr;
    wire swrst_req;
    wire soft_clr;
    wire calc_start;
    wire calc_done;
    wire crc_done;
    wire crc_src_valid;
    wire crc_ctrl_wr;
    wire [31:0] crc_ctrl_m;
    wire crc_en_rise;
    wire [2:0] int_clr;

    // ----------------------------------------
    // apb handshake
    // ----------------------------------------
    assign win = (paddr[11:10] == `WIN_SEL);
    assign eng_owns = (state_q == S_CTRL) || (state_q == S_CNT)
                      || (state_q == S_SRC) || (state_q == S_DST);
    assign access = psel && penable;
    // window reads wait until the ram data belong to this address
    assign capture = access && !pready && (!win || (ram_apb_q && !eng_owns));
    assign commit = access && pready && !pslverr;
    assign wr = commit && pwrite;
    assign swrst_req = pwrite && (paddr == `A_CTRL) && pstrb[0] && pwdata[`F_SWRST];

    always @* begin
        err_d = 1'b0;
        if (!win) begin
            case (paddr)
                `A_CTRL, `A_CRC_CONTROL, `A_STATUS, `A_BASE_ADDR, `A_WRB_ADDR,
                `A_CALC_CMD, `A_SRC_RESULT, `A_DST_RESULT, `A_DESC_LOC,
                `A_WRB_LOC, `A_INT_STATUS, `A_INT_CLEAR, `A_INT_ENABLE: err_d = 1'b0;
                default: err_d = 1'b1;
            endcase
        end
        if (swrst_req && (dma_controller_enabled || crc_enabled)) begin
            err_d = 1'b1;
        end
    end

    always @* begin
        rd_d = 32'h0;
        if (win) begin
            rd_d = ram_q;
            if (paddr[5:2] == `IDX_BLOCK_XFER_CTRL || paddr[5:2] == `IDX_BEAT_COUNT) begin
                rd_d = {16'h0, ram_q[15:0]};
            end
        end else begin
            case (paddr)
                `A_CTRL: rd_d = {29'h0, crc_enabled, dma_controller_enabled, rst_cnt_q != 4'h0};
                `A_CRC_CONTROL: rd_d = {16'h0, crc_ctrl_q};
                `A_STATUS: rd_d = {29'h0, state_q != S_IDLE, rst_cnt_q != 4'h0, crc_in_use};
                `A_BASE_ADDR: rd_d = base_q;
                `A_WRB_ADDR: rd_d = wrb_q;
                `A_CALC_CMD: rd_d = {28'h0, calc_ch_q};
                `A_SRC_RESULT: rd_d = src_res_q;
                `A_DST_RESULT: rd_d = dst_res_q;
                `A_DESC_LOC: rd_d = desc_loc;
                `A_WRB_LOC: rd_d = wrb_loc;
                `A_INT_STATUS: rd_d = {29'h0, int_q};
                `A_INT_ENABLE: rd_d = {29'h0, int_en_q};
                default: rd_d = 32'h0;
            endcase
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            ram_apb_q <= 1'b0;
        end else begin
            ram_apb_q <= !eng_owns;
            if (capture) begin
                pready <= 1'b1;
                pslverr <= err_d;
                prdata <= (pwrite || err_d) ? 32'h0 : rd_d;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // byte lane merge
    // ----------------------------------------
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[8*i+:8] = nw[8*i+:8];
                end
            end
        end
    endfunction

    // ----------------------------------------
    // controller reset and enables
    // ----------------------------------------
    assign soft_clr = (rst_cnt_q == 4'h1);

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_cnt_q <= 4'h0;
            dma_controller_enabled <= 1'b0;
            crc_enabled <= 1'b0;
        end else if (soft_clr) begin
            rst_cnt_q <= 4'h0;
            dma_controller_enabled <= 1'b0;
            crc_enabled <= 1'b0;
        end else if (rst_cnt_q != 4'h0) begin
            rst_cnt_q <= rst_cnt_q - 4'h1;
        end else if (wr && paddr == `A_CTRL && pstrb[0]) begin
            // reset wins over the other bits of the same write
            if (pwdata[`F_SWRST]) begin
                rst_cnt_q <= RST_CNT_INIT;
            end else begin
                dma_controller_enabled <= pwdata[`F_DMA_CONTROLLER_EN];
                crc_enabled <= pwdata[`F_CRC_EN];
            end
        end
    end

    // ----------------------------------------
    // crc source select and lock
    // ----------------------------------------
    assign crc_sel = crc_ctrl_q[`F_CRC_SRC];
    assign crc_src_valid = (crc_sel == `CRC_SRC_IO)
        || (crc_sel >= `CRC_SRC_CHAN0 && crc_sel <= `CRC_SRC_CHAN_LAST);
    // locked source and enable both block the write
    assign crc_ctrl_wr = wr && paddr == `A_CRC_CONTROL && !crc_enabled && !crc_in_use;
    assign crc_ctrl_m = merge({16'h0, crc_ctrl_q}, pwdata, pstrb) & {16'h0, `CRC_CTRL_MASK};
    assign crc_en_rise = wr && paddr == `A_CTRL && pstrb[0] && !pwdata[`F_SWRST]
        && pwdata[`F_CRC_EN] && !crc_enabled && rst_cnt_q == 4'h0;

    genvar g;
    generate
        for (g = 0; g < `NUM_CHANNELS; g = g + 1) begin : chan
            // completion only from the selected channel
            assign chan_hit[g] = crc_chan_select[g] && chan_block_done[g];
        end
    endgenerate

    assign crc_done = crc_in_use && ((crc_io_select && crc_io_done) || (|chan_hit));

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_ctrl_q <= `RST_CRC_CONTROL;
            crc_in_use <= 1'b0;
            crc_complete <= 1'b0;
            crc_io_select <= 1'b0;
            crc_chan_select <= 14'h0;
        end else begin
            crc_complete <= crc_done;
            crc_io_select <= (crc_sel == `CRC_SRC_IO);
            crc_chan_select <= 14'h0;
            if (crc_sel >= `CRC_SRC_CHAN0 && crc_sel <= `CRC_SRC_CHAN_LAST) begin
                crc_chan_select <= 14'h1 << crc_sel[3:0];
            end
            if (soft_clr) begin
                crc_ctrl_q <= `RST_CRC_CONTROL;
                crc_in_use <= 1'b0;
            end else begin
                if (crc_ctrl_wr) begin
                    crc_ctrl_q <= crc_ctrl_m[15:0];
                end
                if (crc_en_rise && crc_src_valid) begin
                    crc_in_use <= 1'b1;
                end else if (crc_done || !crc_enabled) begin
                    crc_in_use <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // descriptor locations
    // ----------------------------------------
    assign desc_loc = base_q + {28'h0, calc_ch_q} * `DESC_STRIDE;
    assign wrb_loc = wrb_q + {28'h0, calc_ch_q} * `DESC_STRIDE;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            base_q <= 32'h0;
            wrb_q <= 32'h0;
        end else if (soft_clr) begin
            base_q <= 32'h0;
            wrb_q <= 32'h0;
        end else if (wr && paddr == `A_BASE_ADDR && !dma_controller_enabled) begin
            base_q <= merge(base_q, pwdata, pstrb);
        end else if (wr && paddr == `A_WRB_ADDR && !dma_controller_enabled) begin
            wrb_q <= merge(wrb_q, pwdata, pstrb);
        end
    end

    // ----------------------------------------
    // descriptor memory, engine has priority
    // ----------------------------------------
    always @* begin
        ram_idx = paddr[5:2];
        case (state_q)
            S_CTRL: ram_idx = `IDX_BLOCK_XFER_CTRL;
            S_CNT: ram_idx = `IDX_BEAT_COUNT;
            S_SRC: ram_idx = `IDX_SOURCE_POINTER;
            S_DST: ram_idx = `IDX_DEST_POINTER;
            default: ram_idx = paddr[5:2];
        endcase
    end

    assign ram_addr = eng_owns ? {calc_ch_q, ram_idx} : paddr[9:2];

    desc_ram u_ram (
        .clk(clk),
        .addr(ram_addr),
        .we(wr && win && !eng_owns),
        .wstrb(pstrb),
        .wdata(pwdata),
        .rdata(ram_q)
    );

    // ----------------------------------------
    // end address engine
    // ----------------------------------------
    assign calc_start = wr && paddr == `A_CALC_CMD && pstrb[1] && pwdata[`F_CALC_START];
    assign calc_done = (state_q == S_CALC);

    addr_step_calc u_src (
        .start(src_q),
        .count(cnt_q),
        .beat_width(ctl_q[`F_BEAT_WIDTH]),
        .step_scale(ctl_q[`F_STEP_SCALE]),
        .incr_en(ctl_q[`F_SRC_INCR]),
        .scale_en(ctl_q[`F_STEP_SEL]),
        .result(src_res)
    );

    addr_step_calc u_dst (
        .start(ram_q),
        .count(cnt_q),
        .beat_width(ctl_q[`F_BEAT_WIDTH]),
        .step_scale(ctl_q[`F_STEP_SCALE]),
        .incr_en(ctl_q[`F_DST_INCR]),
        .scale_en(!ctl_q[`F_STEP_SEL]),
        .result(dst_res)
    );

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= S_IDLE;
            calc_ch_q <= 4'h0;
            ctl_q <= 16'h0;
            cnt_q <= 16'h0;
            src_q <= 32'h0;
            src_res_q <= 32'h0;
            dst_res_q <= 32'h0;
        end else if (soft_clr) begin
            state_q <= S_IDLE;
            calc_ch_q <= 4'h0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    // a start while busy is dropped
                    if (calc_start && pwdata[3:0] < `NUM_CHANNELS) begin
                        calc_ch_q <= pwdata[3:0];
                        state_q <= S_CTRL;
                    end
                end
                S_CTRL: state_q <= S_CNT;
                S_CNT: begin
                    ctl_q <= ram_q[15:0];
                    state_q <= S_SRC;
                end
                S_SRC: begin
                    cnt_q <= ram_q[15:0];
                    state_q <= S_DST;
                end
                S_DST: begin
                    src_q <= ram_q;
                    state_q <= S_CALC;
                end
                S_CALC: begin
                    src_res_q <= src_res;
                    dst_res_q <= dst_res;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // interrupt status
    // ----------------------------------------
    assign int_clr = (wr && paddr == `A_INT_CLEAR && pstrb[0]) ? pwdata[2:0] : 3'h0;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            int_q <= 3'h0;
            int_en_q <= 3'h0;
            irq <= 1'b0;
        end else begin
            // new events win over a clear in the same cycle
            int_q <= (int_q & ~int_clr) | {access && pready && pslverr, crc_done, calc_done};
            if (wr && paddr == `A_INT_ENABLE && pstrb[0]) begin
                int_en_q <= pwdata[2:0];
            end
            irq <= |(int_q & int_en_q);
        end
    end
endmodule // dma_desc_ctrl

`default_nettype wire

// >>> hdl/dma_desc_defs.vh
`ifndef DMA_DESC_DEFS_VH
`define DMA_DESC_DEFS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define RESET_TIME_NS 400
`define RESET_CYCLES ((`RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// descriptor word indices, byte address is four times
// ----------------------------------------
`define IDX_BLOCK_XFER_CTRL 4'h0
`define IDX_BEAT_COUNT 4'h2
`define IDX_SOURCE_POINTER 4'h4
`define IDX_DEST_POINTER 4'h8
`define IDX_NEXT_DESC_POINTER 4'hc
`define DESC_STRIDE 32'h00000010
`define NUM_CHANNELS 14

// ----------------------------------------
// control register byte addresses
// ----------------------------------------
`define IDX_CRC_CONTROL 4'h2
`define A_CTRL 12'h000
`define A_CRC_CONTROL 12'h008
`define A_STATUS 12'h010
`define A_BASE_ADDR 12'h014
`define A_WRB_ADDR 12'h018
`define A_CALC_CMD 12'h01c
`define A_SRC_RESULT 12'h020
`define A_DST_RESULT 12'h024
`define A_DESC_LOC 12'h028
`define A_WRB_LOC 12'h02c
`define A_INT_STATUS 12'h030
`define A_INT_CLEAR 12'h034
`define A_INT_ENABLE 12'h038
`define WIN_SEL 2'b01

// ----------------------------------------
// fields
// ----------------------------------------
`define F_SWRST 0
`define F_DMA_CONTROLLER_EN 1
`define F_CRC_EN 2
`define F_CALC_START 8
`define F_BEAT_WIDTH 9:8
`define F_SRC_INCR 10
`define F_DST_INCR 11
`define F_STEP_SEL 12
`define F_STEP_SCALE 15:13
`define F_CRC_SRC 13:8
`define CRC_CTRL_MASK 16'h3f0f
`define CRC_SRC_IDLE 6'h00
`define CRC_SRC_IO 6'h01
`define CRC_SRC_CHAN0 6'h20
`define CRC_SRC_CHAN_LAST 6'h2d
`define RST_CRC_CONTROL 16'h0000

`endif

// >>> tb/chan_event_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// channel and io completion source
// ----------------------------------------
module chan_event_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // completion pulses
    output logic [13:0] chan_block_done,
    output logic crc_io_done
);
    initial begin
        chan_block_done = 14'h0000;
        crc_io_done = 1'b0;
    end
    // one-cycle done pulse after a wait
    task automatic fire(input int ch, bit io, int wait_cyc);
        repeat (wait_cyc) @(posedge clk);
        if (io)
            crc_io_done <= rst_b;
        else
            chan_block_done[ch] <= rst_b;
        @(posedge clk);
        chan_block_done <= 14'h0000;
        crc_io_done <= 1'b0;
    endtask
endmodule // chan_event_model
`default_nettype wire

// >>> tb/dma_desc_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module dma_desc_ctrl_checker (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // events and crc state
    input wire [13:0] chan_block_done,
    input wire crc_io_done,
    input wire crc_io_select,
    input wire [13:0] crc_chan_select,
    input wire crc_complete,
    input wire crc_in_use,
    input wire dma_controller_enabled,
    input wire crc_enabled,
    input wire irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // reset write seen at its answering edge
    wire rst_req = psel && penable && pready && pwrite && paddr == 12'h000 && pstrb[0] && pwdata[0];
    wire hit = |(chan_block_done & crc_chan_select) || (crc_io_done && crc_io_select);
    wire en_any = dma_controller_enabled || crc_enabled;

    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    AST_PREADY_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_RST_REFUSED: assert property (rst_req && en_any |-> pslverr)
        else $error("reset while enabled not refused");
    AST_RST_ACCEPTED: assert property (rst_req && !en_any |-> !pslverr)
        else $error("reset while disabled refused");
    AST_RST_NO_EFFECT: assert property (rst_req && pslverr |=>
        $stable(dma_controller_enabled) && $stable(crc_enabled))
        else $error("refused reset changed enables");
    AST_DONE_CAUSE: assert property (crc_complete |-> $past(crc_in_use && hit))
        else $error("crc completion without selected source");
    AST_DONE_FIRES: assert property (crc_in_use && hit |=> crc_complete)
        else $error("selected source done but no crc completion");
    AST_ONE_SOURCE: assert property ($onehot0({crc_io_select, crc_chan_select}))
        else $error("more than one crc source selected");
    AST_LOCK_HOLDS: assert property (crc_in_use ##1 crc_in_use |->
        $stable(crc_chan_select) && $stable(crc_io_select))
        else $error("crc source changed while locked");
    AST_LOCK_ENDS: assert property (crc_complete || $fell(crc_enabled) |-> ##[0:1] !crc_in_use)
        else $error("crc lock not released");

    COV_RST_REFUSED: cover property (rst_req && pslverr);
    COV_CRC_DONE: cover property (crc_complete);
    COV_IRQ: cover property (irq);
endmodule // dma_desc_ctrl_checker

bind dma_desc_ctrl dma_desc_ctrl_checker i_dma_desc_ctrl_checker (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_block_done(chan_block_done), .crc_io_done(crc_io_done),
    .crc_io_select(crc_io_select), .crc_chan_select(crc_chan_select),
    .crc_complete(crc_complete), .crc_in_use(crc_in_use), .dma_controller_enabled(dma_controller_enabled),
    .crc_enabled(crc_enabled), .irq(irq));
`default_nettype wire

// >>> tb/dma_desc_ctrl_tb.sv
`timescale 1ns/10ps
`include "dma_desc_defs.vh"
`default_nettype none
module dma_desc_ctrl_tb;
    localparam logic [31:0] BASE = 32'h2000_0000;
    localparam logic [31:0] WRB = 32'h2000_1000;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [13:0] chan_block_done, crc_chan_select;
    logic crc_io_done, crc_io_select, crc_complete, crc_in_use;
    logic dma_controller_enabled, crc_enabled, irq;
    int n_mismatch = 0;
    int n_checks = 0;

    dma_desc_ctrl i_dma_desc_ctrl (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_block_done(chan_block_done), .crc_io_done(crc_io_done),
        .crc_io_select(crc_io_select), .crc_chan_select(crc_chan_select),
        .crc_complete(crc_complete), .crc_in_use(crc_in_use),
        .dma_controller_enabled(dma_controller_enabled), .crc_enabled(crc_enabled), .irq(irq));
    chan_event_model i_chan_event_model (.clk(clk), .rst_b(rst_b),
        .chan_block_done(chan_block_done), .crc_io_done(crc_io_done));

    // ----------------------------------------
    // report and compare
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic need(input logic ok);
        if (ok !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
    endtask
    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // ----------------------------------------
    // apb master
    // ----------------------------------------
    task automatic apb(input logic w, logic [11:0] a, logic [31:0] wd, logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        // window stalls while the engine reads
        for (int i = 0; i < 50 && pready !== 1'b1; i++)
            @(posedge clk);
        need(pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, logic [31:0] wd);
        apb(1'b1, a, wd, 4'hf);
    endtask
    task automatic rchk(input logic [11:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(rd, e);
    endtask
    function automatic logic [11:0] wa(input logic [3:0] ch, ix);
        return {`WIN_SEL, ch, ix, 2'b00};
    endfunction
    function automatic logic [31:0] ea(input logic [31:0] st, logic [15:0] n, c, logic dst);
        logic [31:0] step;
        step = {30'h0, c[9:8]} + 32'h1;
        if (dst ^ c[12])
            step = step << c[15:13];
        return (dst ? c[11] : c[10]) ? st + n * step : st;
    endfunction

    // ----------------------------------------
    // descriptor calculation
    // ----------------------------------------
    task automatic calc(input logic [3:0] ch, logic [15:0] c, n, logic [31:0] s, dd);
        wr(wa(ch, 4'h0), {16'h0, c});
        wr(wa(ch, 4'h2), {16'h0, n});
        wr(wa(ch, 4'h4), s);
        wr(wa(ch, 4'h8), dd);
        rchk(wa(ch, 4'h0), {16'h0, c});
        wr(`A_INT_CLEAR, 32'h1);
        wr(`A_CALC_CMD, {23'h0, 1'b1, 4'h0, ch});
        rd = 32'h0;
        for (int i = 0; i < 20 && rd[0] !== 1'b1; i++)
            apb(1'b0, `A_INT_STATUS, 32'h0, 4'h0);
        need(rd[0]);
        rchk(`A_SRC_RESULT, ea(s, n, c, 1'b0));
        rchk(`A_DST_RESULT, ea(dd, n, c, 1'b1));
        rchk(`A_DESC_LOC, BASE + `DESC_STRIDE * ch);
        rchk(`A_WRB_LOC, WRB + `DESC_STRIDE * ch);
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_b = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rchk(`A_CRC_CONTROL, {16'h0, `RST_CRC_CONTROL});
        rchk(`A_STATUS, 32'h0);
        rchk(12'h03c, 32'h0);
        chk(err, 1'b1);
        wr(`A_BASE_ADDR, BASE);
        wr(`A_WRB_ADDR, WRB);
        wr(`A_INT_ENABLE, 32'h1);
        calc(4'h0, 16'h4d00, 16'h0010, 32'h1000, 32'h2000);
        chk(irq, 1'b1);
        wr(`A_INT_ENABLE, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        wr(`A_INT_CLEAR, 32'h7);
        wr(`A_INT_ENABLE, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        rchk(`A_INT_STATUS, 32'h0);
        calc(4'hd, 16'hfe00, 16'hffff, 32'h1000_0000, 32'h3000_0000);
        calc(4'h5, 16'h0300, 16'h0020, 32'h4000, 32'h5000);
        apb(1'b1, wa(4'h5, 4'h4), 32'haabbccdd, 4'b0010);
        rchk(wa(4'h5, 4'h4), 32'h0000cc00);
        apb(1'b1, wa(4'h5, 4'h4), 32'h12345678, 4'b1100);
        rchk(wa(4'h5, 4'h4), 32'h1234cc00);
        // every source code from 0x00 to 0x2d, lock only on valid ones
        for (int i = 0; i <= 'h2d; i++) begin
            wr(`A_CRC_CONTROL, {18'h0, i[5:0], 8'h00});
            wr(`A_CTRL, 32'h4);
            repeat (2) @(posedge clk);
            chk(crc_in_use, i == 1 || i >= 'h20);
            chk(crc_io_select, i == 1);
            chk(crc_chan_select, i >= 'h20 ? 14'h1 << (i - 'h20) : 14'h0);
            wr(`A_CTRL, 32'h0);
        end
        wr(`A_INT_CLEAR, 32'h7);
        wr(`A_CRC_CONTROL, 32'h2305);
        wr(`A_CTRL, 32'h4);
        wr(`A_CRC_CONTROL, 32'h2a00);
        rchk(`A_CRC_CONTROL, 32'h2305);
        i_chan_event_model.fire(2, 1'b0, 1);
        rchk(`A_STATUS, 32'h1);
        i_chan_event_model.fire(3, 1'b0, 3);
        rchk(`A_STATUS, 32'h0);
        rchk(`A_INT_STATUS, 32'h2);
        wr(`A_CRC_CONTROL, 32'h2a00);
        rchk(`A_CRC_CONTROL, 32'h2305);
        wr(`A_CTRL, 32'h0);
        wr(`A_CRC_CONTROL, 32'h0100);
        rchk(`A_CRC_CONTROL, 32'h0100);
        wr(`A_CTRL, 32'h4);
        i_chan_event_model.fire(0, 1'b1, 2);
        rchk(`A_STATUS, 32'h0);
        wr(`A_CTRL, 32'h0);
        wr(`A_INT_CLEAR, 32'h7);
        // controller reset refused while enabled, then accepted
        wr(`A_CTRL, 32'h2);
        apb(1'b1, `A_CTRL, 32'h3, 4'hf);
        chk(err, 1'b1);
        rchk(`A_CTRL, 32'h2);
        wr(`A_CTRL, 32'h0);
        wr(`A_CRC_CONTROL, 32'h0101);
        apb(1'b1, `A_CTRL, 32'h1, 4'h1);
        chk(err, 1'b0);
        rchk(`A_CTRL, 32'h1);
        rchk(`A_STATUS, 32'h0);
        rchk(`A_CRC_CONTROL, 32'h0);
        rchk(`A_INT_STATUS, 32'h4);
        end_sim();
    end
endmodule // dma_desc_ctrl_tb
`default_nettype wire
